//--- design/trcd_ram.sv
// What this block does
// - Read drives bus; write loads bus data.
// - Compare loads bus data, outputs hit.
// - Deselect: bus undriven, hit high when enabled.
// - Active only when lo=0 and hi=1.
// - Output enables act without the clock.
// - Bus drive needs enable low and registered read data valid.
// - Controller releases bus before write after read.
// - Controller holds bus released through write.
// - Input register loads only when load low.
// - Read data appears two cycles later.
// - Hit result appears two cycles after compare.
// - Fill writes data held from last write or compare.
`timescale 1ns/100ps
module trcd_ram
  import trcd_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Controller side
  trcd_if.ram       bus
);
  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] addr_reg;
  logic              hi_reg;
  logic              lo_reg;
  logic              wr_n_reg;
  logic              load_n_reg;
  logic [DATA_W-1:0] din_reg;
  logic [DATA_W-1:0] rd_reg;
  logic [DATA_W-1:0] dout_reg;
  logic              rd_valid_reg;
  logic              dout_valid_reg;
  logic              cmp_reg;
  logic              hit_reg;
  logic              hit_pin_reg;
  logic              desel_reg;
  logic              desel_pin_reg;
  trcd_cycle_t       cyc;

  // Input registers; data register loads only when load is low
  always_ff @(posedge clk) begin
    addr_reg   <= bus.addr;
    hi_reg     <= bus.enable_hi_in;
    lo_reg     <= bus.enable_lo_in;
    wr_n_reg   <= bus.write_cmd_n;
    load_n_reg <= bus.input_load_n;
    if (srst) begin
      hi_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      din_reg <= DATA_RST;
    end else if (!bus.input_load_n) begin
      din_reg <= bus.dq_from_ctl;
    end
  end

  // Cycle decode of the registered controls
  assign cyc = trcd_decode(hi_reg, lo_reg, wr_n_reg, load_n_reg);

  // Array: self-timed write on write and fill, none when deselected
  always_ff @(posedge clk) begin
    if (cyc == TRCD_WRITE || cyc == TRCD_FILL) begin
      mem[addr_reg] <= din_reg;
    end
  end

  // First pipe stage: array read and compare
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_valid_reg <= 1'b0;
      cmp_reg      <= 1'b0;
      desel_reg    <= 1'b1;
      hit_reg      <= 1'b0;
      rd_reg       <= DATA_RST;
    end else begin
      rd_valid_reg <= (cyc == TRCD_READ);
      cmp_reg      <= (cyc == TRCD_COMPARE);
      desel_reg    <= (cyc == TRCD_DESEL);
      if (cyc == TRCD_READ || cyc == TRCD_COMPARE) begin
        rd_reg  <= mem[addr_reg];
        hit_reg <= (mem[addr_reg] == din_reg);
      end
    end
  end

  // Output register stage
  always_ff @(posedge clk) begin
    if (srst) begin
      dout_valid_reg <= 1'b0;
      dout_reg       <= DATA_RST;
      hit_pin_reg    <= 1'b1;
      desel_pin_reg  <= 1'b1;
    end else begin
      dout_valid_reg <= rd_valid_reg;
      dout_reg       <= rd_reg;
      desel_pin_reg  <= desel_reg;
      if (cmp_reg) begin
        hit_pin_reg <= hit_reg;
      end else if (desel_reg) begin
        hit_pin_reg <= 1'b1;
      end
    end
  end

  // Asynchronous output enables gate the registered drivers
  assign bus.dq_from_ram = dout_reg;
  assign bus.dq_ram_oe   = dout_valid_reg && !bus.bus_drive_en_n;
  assign bus.tag_hit_o   = hit_pin_reg;
  assign bus.tag_hit_oe  = !bus.hit_drive_en_n;
endmodule

//--- design/trcd_pkg.sv
package trcd_pkg;
  // Array geometry
  localparam int ADDR_W  = 16;
  localparam int DATA_W  = 18;
  localparam int DEPTH   = 65536;
  // Pipeline depth from command to data or hit on the pins
  localparam int PIPE_CYC = 2;
  // Controller: idle cycles forced after a read before a write may follow
  localparam int RD_TO_WR_GAP = 3;
  localparam logic [1:0] GAP_RST = 2'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;

  // Cycle kinds decoded from the registered controls
  typedef enum logic [4:0] {
    TRCD_DESEL   = 5'b00001,
    TRCD_READ    = 5'b00010,
    TRCD_WRITE   = 5'b00100,
    TRCD_COMPARE = 5'b01000,
    TRCD_FILL    = 5'b10000
  } trcd_cycle_t;

  // Decode of one cycle from selects, write and load controls
  function automatic trcd_cycle_t trcd_decode(input logic en_hi, input logic en_lo,
                                              input logic wr_n, input logic load_n);
    if (!(en_hi && !en_lo)) begin
      trcd_decode = TRCD_DESEL;
    end else if (wr_n && load_n) begin
      trcd_decode = TRCD_READ;
    end else if (wr_n) begin
      trcd_decode = TRCD_COMPARE;
    end else if (!load_n) begin
      trcd_decode = TRCD_WRITE;
    end else begin
      trcd_decode = TRCD_FILL;
    end
  endfunction
endpackage

//--- design/trcd_if.sv
`timescale 1ns/100ps
interface trcd_if (input wire logic clk);
  import trcd_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic              enable_hi_in;
  logic              enable_lo_in;
  logic              write_cmd_n;
  logic              input_load_n;
  logic              bus_drive_en_n;
  logic              hit_drive_en_n;
  // Data bus as separate drive halves
  logic [DATA_W-1:0] dq_from_ctl;
  logic              dq_ctl_oe;
  logic [DATA_W-1:0] dq_from_ram;
  logic              dq_ram_oe;
  logic              tag_hit_o;
  logic              tag_hit_oe;

  modport ram (input addr, enable_hi_in, enable_lo_in, write_cmd_n, input_load_n,
               bus_drive_en_n, hit_drive_en_n, dq_from_ctl,
               output dq_from_ram, dq_ram_oe, tag_hit_o, tag_hit_oe);
  modport ctl (output addr, enable_hi_in, enable_lo_in, write_cmd_n, input_load_n,
               bus_drive_en_n, hit_drive_en_n, dq_from_ctl, dq_ctl_oe,
               input dq_from_ram, dq_ram_oe, tag_hit_o, tag_hit_oe);
endinterface

//--- design/trcd_ctl.sv
`timescale 1ns/100ps
module trcd_ctl
  import trcd_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // User request
  input  wire trcd_cycle_t       req_kind,
  input  wire logic              req_valid,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_data,
  output logic                   req_ready,
  // Results
  output logic [DATA_W-1:0]      rd_data,
  output logic                   rd_valid,
  output logic                   hit,
  output logic                   hit_valid,
  // Tag RAM side
  trcd_if.ctl                    bus
);
  logic [1:0]        gap_reg;
  logic [2:0]        rd_pipe_reg;
  logic [2:0]        cmp_pipe_reg;
  logic              oe_n_reg;
  logic              go;
  logic              is_wr;
  logic              bus_turn;

  // Any cycle that loads the bus or writes waits out the read turnaround
  assign is_wr     = (req_kind == TRCD_WRITE) || (req_kind == TRCD_FILL);
  assign bus_turn  = is_wr || (req_kind == TRCD_COMPARE);
  assign go        = req_valid && !(bus_turn && gap_reg != GAP_RST);
  assign req_ready = !(bus_turn && gap_reg != GAP_RST);

  // Pin drive of the next cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      bus.enable_hi_in <= 1'b0;
      bus.enable_lo_in <= 1'b1;
      bus.write_cmd_n  <= 1'b1;
      bus.input_load_n <= 1'b1;
      bus.addr         <= '0;
      bus.dq_from_ctl  <= DATA_RST;
      bus.dq_ctl_oe    <= 1'b0;
    end else begin
      bus.enable_hi_in <= go && req_kind != TRCD_DESEL;
      bus.enable_lo_in <= !(go && req_kind != TRCD_DESEL);
      bus.write_cmd_n  <= !(go && is_wr);
      bus.input_load_n <= !(go && (req_kind == TRCD_WRITE || req_kind == TRCD_COMPARE));
      bus.addr         <= req_addr;
      bus.dq_from_ctl  <= req_data;
      bus.dq_ctl_oe    <= go && (req_kind == TRCD_WRITE || req_kind == TRCD_COMPARE);
    end
  end

  // Read to write spacing and bus enable
  always_ff @(posedge clk) begin
    if (srst) begin
      gap_reg  <= GAP_RST;
      oe_n_reg <= 1'b1;
    end else begin
      if (go && req_kind == TRCD_READ) begin
        gap_reg <= 2'(RD_TO_WR_GAP);
      end else if (gap_reg != GAP_RST) begin
        gap_reg <= gap_reg - 2'h1;
      end
      oe_n_reg <= !(go && req_kind == TRCD_READ) && !rd_pipe_reg[0]
                  && !rd_pipe_reg[1];
    end
  end
  assign bus.bus_drive_en_n = oe_n_reg;
  // Match driver only on while a compare result stands on the pin
  assign bus.hit_drive_en_n = !cmp_pipe_reg[2];

  // Result pipes
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_pipe_reg  <= 3'h0;
      cmp_pipe_reg <= 3'h0;
      rd_valid     <= 1'b0;
      hit_valid    <= 1'b0;
      rd_data      <= DATA_RST;
      hit          <= 1'b0;
    end else begin
      rd_pipe_reg  <= {rd_pipe_reg[1:0], !bus.write_cmd_n ? 1'b0 :
                       (bus.enable_hi_in && bus.input_load_n)};
      cmp_pipe_reg <= {cmp_pipe_reg[1:0], bus.enable_hi_in && bus.write_cmd_n && !bus.input_load_n};
      rd_valid     <= rd_pipe_reg[2];
      hit_valid    <= cmp_pipe_reg[2];
      rd_data      <= bus.dq_ram_oe ? bus.dq_from_ram : DATA_RST;    // Undriven bus reads as zero
      hit          <= bus.tag_hit_oe && bus.tag_hit_o;               // Floating match reads as low
    end
  end
endmodule

//--- verif/trcd_checker.sv
`timescale 1ns/100ps
module trcd_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Interface pins
  input wire logic enable_hi_in,
  input wire logic enable_lo_in,
  input wire logic write_cmd_n,
  input wire logic input_load_n,
  input wire logic bus_drive_en_n,
  input wire logic hit_drive_en_n,
  input wire logic dq_ctl_oe,
  input wire logic dq_ram_oe,
  input wire logic tag_hit_o,
  input wire logic tag_hit_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Chip selected only for lo low and hi high
  wire sel = enable_hi_in && !enable_lo_in;
  // Cycle kinds seen on the pins
  sequence s_rd;   sel && write_cmd_n && input_load_n;   endsequence
  sequence s_wr;   sel && !write_cmd_n && !input_load_n; endsequence
  sequence s_cmp;  sel && write_cmd_n && !input_load_n;  endsequence
  sequence s_fill; sel && !write_cmd_n && input_load_n;  endsequence
  AST_OE_GATES: assert property (bus_drive_en_n |-> !dq_ram_oe) else $error("bus driven while off");
  AST_HIT_OE: assert property (tag_hit_oe == !hit_drive_en_n) else $error("hit enable wrong");
  AST_DESEL_HIT: assert property (!sel [*5] |-> tag_hit_o) else $error("hit not high");
  AST_WR: assert property (s_wr |-> bus_drive_en_n && dq_ctl_oe && !dq_ram_oe) else $error("write drive");
  AST_CMP: assert property (s_cmp |-> bus_drive_en_n && dq_ctl_oe && !dq_ram_oe) else $error("compare drive");
  AST_FILL: assert property (s_fill |-> !dq_ram_oe) else $error("fill drives bus");
  AST_NO_CONTEND: assert property (!(dq_ram_oe && dq_ctl_oe)) else $error("bus contention");
  AST_RD_DATA: assert property (s_rd [*3] |-> ##[0:2] dq_ram_oe) else $error("read data absent");
  AST_RD_LAT: assert property (s_rd |-> ##3 dq_ram_oe) else $error("read data not on bus");
  AST_CMP_LAT: assert property (s_cmp |-> ##3 tag_hit_oe) else $error("match not driven");
endmodule

//--- verif/testbench.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fail_count++; $display("Error %s expected %h seen %h", nm, ex, got); end end
module testbench;
  import trcd_pkg::*;
  logic              clk, srst, req_valid, req_ready, rd_valid, hit, hit_valid, exp_h;
  trcd_cycle_t       req_kind, k;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_data, rd_data, last_load, d, exp_d;
  logic [DATA_W-1:0] mem [4];
  logic [DATA_W-1:0] rd_q [$];
  logic              hit_q [$];
  logic [1:0]        a;
  int                fail_count, comparisons, cycles;
  trcd_cycle_t       kinds [5] = '{TRCD_WRITE, TRCD_READ, TRCD_COMPARE, TRCD_FILL, TRCD_DESEL};

  // Both ends joined by the interface
  trcd_if bus_if (.clk(clk));
  trcd_ram trcd_ram_i (.clk(clk), .srst(srst), .bus(bus_if.ram));
  trcd_ctl trcd_ctl_i (.clk(clk), .srst(srst), .req_kind(req_kind), .req_valid(req_valid), .req_addr(req_addr),
    .req_data(req_data), .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid), .hit(hit),
    .hit_valid(hit_valid), .bus(bus_if.ctl));
  trcd_checker trcd_checker_i (.clk(clk), .srst(srst), .enable_hi_in(bus_if.enable_hi_in),
    .enable_lo_in(bus_if.enable_lo_in), .write_cmd_n(bus_if.write_cmd_n), .input_load_n(bus_if.input_load_n),
    .bus_drive_en_n(bus_if.bus_drive_en_n), .hit_drive_en_n(bus_if.hit_drive_en_n), .dq_ctl_oe(bus_if.dq_ctl_oe),
    .dq_ram_oe(bus_if.dq_ram_oe), .tag_hit_o(bus_if.tag_hit_o), .tag_hit_oe(bus_if.tag_hit_oe));

  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Verdict and end of run
  task automatic complete_run();
    if (fail_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One request, held until taken; expectations noted at the taking edge
  task automatic issue(input trcd_cycle_t kd, input logic [1:0] ad, input logic [DATA_W-1:0] dd);
    int n;
    n = 0;
    req_kind = kd;
    req_addr = {14'h0000, ad};
    req_data = dd;
    req_valid = 1'b1;
    #1;
    while (req_ready !== 1'b1 && n < 10) begin
      @(negedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    if (kd == TRCD_READ) rd_q.push_back(mem[ad]);
    if (kd == TRCD_COMPARE) hit_q.push_back(dd == mem[ad]);
    if (kd == TRCD_WRITE || kd == TRCD_COMPARE) last_load = dd;
    if (kd == TRCD_WRITE) mem[ad] = dd;
    if (kd == TRCD_FILL) mem[ad] = last_load;
    @(negedge clk);
  endtask

  // Result watcher
  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      exp_d = rd_q.pop_front();
      `CHK("rd_data", exp_d, rd_data)
    end
    if (hit_valid === 1'b1) begin
      exp_h = hit_q.pop_front();
      `CHK("hit", exp_h, hit)
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      complete_run();
    end
  end

  // Main sequence
  initial begin
    void'($urandom(42880));
    srst = 1'b1;
    req_valid = 1'b0;
    req_kind = TRCD_DESEL;
    req_addr = '0;
    req_data = '0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    for (int i = 0; i < 4; i++) issue(TRCD_WRITE, 2'(i), DATA_W'($urandom));
    // Deselect between compare and fill keeps the loaded tag
    issue(TRCD_COMPARE, 2'h0, 18'h2A5A5);
    issue(TRCD_DESEL, 2'h0, 18'h00000);
    issue(TRCD_FILL, 2'h1, 18'h00000);
    issue(TRCD_READ, 2'h1, 18'h00000);
    // Back to back reads keep the bus enable low across results
    for (int i = 0; i < 3; i++) issue(TRCD_READ, 2'(i), 18'h00000);
    for (int i = 0; i < 60; i++) begin
      k = kinds[$urandom_range(4)];
      a = 2'($urandom);
      d = $urandom_range(1) ? mem[a] : DATA_W'($urandom);
      issue(k, a, d);
    end
    req_valid = 1'b0;
    repeat (10) @(negedge clk);
    `CHK("pending", 0, rd_q.size() + hit_q.size())
    complete_run();
  end
endmodule
